/* verilog/ccfet_pkg.sv */
// Package for the card command frame receiver and its host-side sender.
// Assumes a one-bit command line clocked by a host-made serial clock.
// Function
// - Host starts all; card answers only when asked
// - Byte is the basic transfer unit
// - Block size reported in card data register; here BLK_LEN_EXP is a package constant, never output
// - Sector, erase group, protect group sizes fixed
// - Tag bit per sector and group; erase all
// - Non-tag command clears every erase tag
// - Host sends erase right after tag commands
// - One protect bit per write-protect group
// - Accept basic, stream read, block read commands
// - Accept write, protect, erase, lock commands
// - Supported classes coded in card data register
// - Broadcast commands answered by none or all
// - Addressed commands answered by addressed card only; the card here never drives a response
// - Frames shifted most significant bit first
// - Every frame is exactly 48 bits
// - Start, host, index, argument, CRC, end order
// - Start bit is always zero
// - Host bit is always one
// - Index field is binary command number
package ccfet_pkg;
  localparam int FRAME_BITS       = 48;
  localparam int CRC_BITS         = 7;
  localparam int CRC_COVER        = 40;
  localparam logic [6:0] CRC_POLY = 7'h09;   // x^7+x^3+1
  localparam int BLK_LEN_EXP      = 9;       // 512-byte block
  localparam int SECTOR_SIZE_F    = 0;
  localparam int ERASE_GRP_SIZE_F = 15;
  localparam int WP_GRP_SIZE_F    = 1;
  localparam int SECTORS          = 16;      // Modelled sectors
  localparam int GROUPS           = 4;       // Modelled erase groups
  localparam int WP_GROUPS        = 2;       // Modelled protect groups
  localparam logic [11:0] CMD_CLASS = 12'h0ff; // Classes 0..7
  // Command numbers
  localparam logic [5:0] CMD_IDLE      = 6'h00;
  localparam logic [5:0] CMD_SEL       = 6'h07;
  localparam logic [5:0] CMD_SET_WP    = 6'h1c;
  localparam logic [5:0] CMD_CLR_WP    = 6'h1d;
  localparam logic [5:0] CMD_TAG_SEC_S = 6'h20;
  localparam logic [5:0] CMD_TAG_SEC_E = 6'h21;
  localparam logic [5:0] CMD_UNTAG_SEC = 6'h22;
  localparam logic [5:0] CMD_TAG_GRP_S = 6'h23;
  localparam logic [5:0] CMD_TAG_GRP_E = 6'h24;
  localparam logic [5:0] CMD_UNTAG_GRP = 6'h25;
  localparam logic [5:0] CMD_ERASE     = 6'h26;
  localparam logic [63:0] CMD_SUPPORTED = 64'h0000_047f_7f17_be9f;

  function automatic logic [6:0] crc7_step(input logic [6:0] c, input logic b);
    logic fb;
    fb = c[6] ^ b;
    crc7_step = {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
  endfunction
endpackage

/* verilog/ccfet_if.sv */
// Interface joining host and card over the command line and serial clock.
// Assumes the testbench resolves the open-drain line from the enables.
`timescale 1ns/100ps
interface ccfet_if;
  logic sclk;        // Serial clock made by host
  logic cmd_host_o;  // Host drive value
  logic cmd_host_oe_n;
  logic cmd_card_o;  // Card drive value
  logic cmd_card_oe_n;
  logic cmd_in;      // Resolved line level
  modport host (output sclk, output cmd_host_o, output cmd_host_oe_n, input cmd_in);
  modport card (input sclk, output cmd_card_o, output cmd_card_oe_n, input cmd_in);
endinterface

/* verilog/ccfet_host.sv */
// Host end: sends one 48-bit command frame per request, making the serial clock.
// Assumes mclk at 20 MHz; the serial clock is mclk divided by two.
`timescale 1ns/100ps
module ccfet_host (
  input  wire logic        mclk,
  input  wire logic        rst,
  ccfet_if.host            bus,
  input  wire logic        req,
  input  wire logic [5:0]  req_index,
  input  wire logic [31:0] req_arg,
  output logic             busy
);
  logic [47:0] sh_reg;
  logic [5:0]  cnt_reg;
  logic        sclk_reg;
  logic [6:0]  crc;
  logic [39:0] head;

  // Frame head and CRC over its 40 bits
  always_comb begin
    head = {1'b0, 1'b1, req_index, req_arg};
    crc  = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      crc = ccfet_pkg::crc7_step(crc, head[i]);
    end
  end

  // Shifter: host alone starts traffic, MSB first, 48 bits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sh_reg   <= '1;
      cnt_reg  <= 6'h00;
      sclk_reg <= 1'b0;
      busy     <= 1'b0;
    end else if (!busy) begin
      sclk_reg <= 1'b0;
      if (req) begin
        sh_reg  <= {head, crc, 1'b1};
        cnt_reg <= 6'(ccfet_pkg::FRAME_BITS);
        busy    <= 1'b1;
      end
    end else begin
      sclk_reg <= ~sclk_reg;
      if (sclk_reg) begin                      // Shift after card samples rising edge
        sh_reg  <= {sh_reg[46:0], 1'b1};
        cnt_reg <= cnt_reg - 6'h01;
        if (cnt_reg == 6'h01) begin
          busy <= 1'b0;
        end
      end
    end
  end

  assign bus.sclk          = sclk_reg;
  assign bus.cmd_host_o    = sh_reg[47];
  assign bus.cmd_host_oe_n = ~busy;
endmodule // ccfet_host

/* verilog/ccfet_card.sv */
// Card end: receives command frames, checks them, keeps tags and protect bits.
// Assumes the serial clock idles low and the line idles high.
`timescale 1ns/100ps
module ccfet_card #(
  parameter int SECTORS   = ccfet_pkg::SECTORS,
  parameter int GROUPS    = ccfet_pkg::GROUPS,
  parameter int WP_GROUPS = ccfet_pkg::WP_GROUPS
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  ccfet_if.card            bus,
  output logic             cmd_valid,
  output logic [5:0]       cmd_index,
  output logic [31:0]      cmd_arg,
  output logic             erase_pulse,
  output logic [SECTORS-1:0]   sec_tag,
  output logic [GROUPS-1:0]    grp_tag,
  output logic [WP_GROUPS-1:0] wp_bits,
  output logic             selected,
  output logic [11:0]      card_command_class
);
  typedef enum logic [1:0] {CCFET_IDLE = 2'b00, CCFET_RECV = 2'b01} ccfet_state_t;
  ccfet_state_t st_reg;
  logic [46:0]  sh_reg;
  logic [5:0]   cnt_reg;
  // The link side runs on the host's serial clock and only collects bits.
  // A finished frame is parked in frm_reg and crc_frm_reg, and a toggle
  // announces it to the mclk side. The parked words stay still until the
  // next frame ends, which is far longer than the toggle takes to cross,
  // so the mclk side may read them without further handshaking.
  logic [6:0]   crc_reg;      // Running check over the first 40 bits
  logic [6:0]   crc_frm_reg;  // Check value parked with the frame
  logic         tgl_reg;
  logic [47:0]  frm_reg;
  logic         s1, s2, s3;
  logic         good;
  logic [5:0]   idx;
  logic [31:0]  arg;
  // Decoded command kinds and the unit each one points at
  logic [$clog2(SECTORS)-1:0]   sec_idx;
  logic [$clog2(GROUPS)-1:0]    grp_idx;
  logic [$clog2(WP_GROUPS)-1:0] wp_idx;
  logic         is_tag_sec;
  logic         is_untag_sec;
  logic         is_tag_grp;
  logic         is_untag_grp;
  logic         keeps_tags;

  // Link domain: collect 48 bits on the serial clock
  always_ff @(posedge bus.sclk or posedge rst) begin
    if (rst) begin
      st_reg  <= CCFET_IDLE;
      cnt_reg <= 6'h00;
      sh_reg  <= '0;
      crc_reg <= 7'h00;
      tgl_reg <= 1'b0;
      frm_reg <= '0;
      crc_frm_reg <= 7'h00;
    end else begin
      case (st_reg)
        CCFET_IDLE: begin
          if (!bus.cmd_in) begin               // Start bit zero
            st_reg  <= CCFET_RECV;
            cnt_reg <= 6'h01;
            sh_reg  <= '0;
            crc_reg <= ccfet_pkg::crc7_step(7'h00, 1'b0);
          end
        end
        CCFET_RECV: begin
          sh_reg  <= {sh_reg[45:0], bus.cmd_in};
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg < 6'(ccfet_pkg::CRC_COVER)) begin
            crc_reg <= ccfet_pkg::crc7_step(crc_reg, bus.cmd_in);
          end
          if (cnt_reg == 6'(ccfet_pkg::FRAME_BITS - 1)) begin
            st_reg  <= CCFET_IDLE;
            frm_reg <= {sh_reg, bus.cmd_in};
            crc_frm_reg <= crc_reg;             // Final check value
            tgl_reg <= ~tgl_reg;                // Frame event crosses as a toggle
          end
        end
        default: st_reg <= CCFET_IDLE;
      endcase
    end
  end

  // Toggle synchroniser into mclk
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= tgl_reg;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Frame check; frame word is stable once the toggle has crossed
  assign idx  = frm_reg[45:40];
  assign arg  = frm_reg[39:8];
  assign good = (frm_reg[47] == 1'b0) && frm_reg[46] && frm_reg[0]
             && (crc_frm_reg == frm_reg[7:1]);

  // Decoded command stream
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd_index <= 6'h00;
      cmd_arg   <= 32'h0000_0000;
    end else begin
      cmd_valid <= (s2 ^ s3) && good && ccfet_pkg::CMD_SUPPORTED[idx];
      if ((s2 ^ s3) && good) begin
        cmd_index <= idx;
        cmd_arg   <= arg;
      end
    end
  end

  // Command kinds and unit indices taken from the held command word
  assign sec_idx      = cmd_arg[$clog2(SECTORS)+8:9];
  assign grp_idx      = cmd_arg[$clog2(GROUPS)+12:13];
  assign wp_idx       = cmd_arg[$clog2(WP_GROUPS)+13:14];
  assign is_tag_sec   = (cmd_index == ccfet_pkg::CMD_TAG_SEC_S) || (cmd_index == ccfet_pkg::CMD_TAG_SEC_E);
  assign is_untag_sec = (cmd_index == ccfet_pkg::CMD_UNTAG_SEC);
  assign is_tag_grp   = (cmd_index == ccfet_pkg::CMD_TAG_GRP_S) || (cmd_index == ccfet_pkg::CMD_TAG_GRP_E);
  assign is_untag_grp = (cmd_index == ccfet_pkg::CMD_UNTAG_GRP);
  assign keeps_tags   = is_tag_sec || is_untag_sec || is_tag_grp || is_untag_grp;

  // Sector tag bits; any command other than a sector or group tag or untag command wipes them
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sec_tag <= '0;
    end else if (cmd_valid) begin
      if (is_tag_sec) begin
        sec_tag[sec_idx] <= 1'b1;
      end else if (is_untag_sec) begin
        sec_tag[sec_idx] <= 1'b0;
      end else if (!keeps_tags) begin
        sec_tag <= '0;
      end
    end
  end

  // Group tag bits; any command other than a sector or group tag or untag command wipes them
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      grp_tag <= '0;
    end else if (cmd_valid) begin
      if (is_tag_grp) begin
        grp_tag[grp_idx] <= 1'b1;
      end else if (is_untag_grp) begin
        grp_tag[grp_idx] <= 1'b0;
      end else if (!keeps_tags) begin
        grp_tag <= '0;
      end
    end
  end

  // Erase fires once for all tagged units, using the tags before they clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      erase_pulse <= 1'b0;
    end else begin
      erase_pulse <= cmd_valid && (cmd_index == ccfet_pkg::CMD_ERASE) && (|{sec_tag, grp_tag});
    end
  end

  // Protect bit per protect group; the idle command drops them all
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_bits <= '0;
    end else if (cmd_valid) begin
      if (cmd_index == ccfet_pkg::CMD_SET_WP) begin
        wp_bits[wp_idx] <= 1'b1;
      end else if (cmd_index == ccfet_pkg::CMD_CLR_WP) begin
        wp_bits[wp_idx] <= 1'b0;
      end else if (cmd_index == ccfet_pkg::CMD_IDLE) begin
        wp_bits <= '0;
      end
    end
  end

  // Selection: nonzero address selects, zero or idle deselects
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      selected <= 1'b0;
    end else if (cmd_valid) begin
      if (cmd_index == ccfet_pkg::CMD_SEL) begin
        selected <= (cmd_arg[31:16] != 16'h0000);
      end else if (cmd_index == ccfet_pkg::CMD_IDLE) begin
        selected <= 1'b0;
      end
    end
  end

  // Class code output
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      card_command_class <= 12'h000;
    end else begin
      card_command_class <= ccfet_pkg::CMD_CLASS;
    end
  end

  // No response path: card never drives the line here
  assign bus.cmd_card_o    = 1'b1;
  assign bus.cmd_card_oe_n = 1'b1;
endmodule // ccfet_card

/* testbench/ccfet_properties.sv */
// Checker for the command line joining the host end and the card end.
// Assumes it sits beside the interface in the bench top, mclk domain.
`timescale 1ns/100ps
module ccfet_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cmd_host_o,
  input wire logic cmd_host_oe_n,
  input wire logic cmd_card_o,
  input wire logic cmd_card_oe_n,
  input wire logic cmd_in
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic       sclk_reg;
  logic       oe_reg;
  logic [6:0] rise_reg;
  // Counts serial clock rises since the host took the line
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_reg <= 1'b0;
      oe_reg   <= 1'b1;
      rise_reg <= 7'h00;
    end else begin
      sclk_reg <= sclk;
      oe_reg   <= cmd_host_oe_n;
      if (!cmd_host_oe_n && oe_reg)
        rise_reg <= 7'h00;
      else if (sclk && !sclk_reg)
        rise_reg <= rise_reg + 7'h01;
    end
  end
  // Frame boundaries seen at the host driver enable
  sequence frame_start;
    $fell(cmd_host_oe_n);
  endsequence
  sequence frame_end;
    $rose(cmd_host_oe_n);
  endsequence
  a_start_bit_zero: assert property (frame_start |-> !cmd_host_o) else $error("start bit not zero");
  a_host_bit_one: assert property (frame_start |-> ##2 cmd_host_o) else $error("host bit not one");
  a_end_bit_one: assert property (frame_end |-> $past(cmd_host_o)) else $error("end bit not one");
  a_frame_len_48: assert property (frame_end |=> rise_reg == 7'd48) else $error("frame not 48 bits");
  a_bit_held_high: assert property (!cmd_host_oe_n && sclk |-> $stable(cmd_host_o)) else $error("bit moved");
  a_sclk_toggles: assert property (!cmd_host_oe_n && !oe_reg |-> sclk != $past(sclk)) else $error("no toggle");
  a_sclk_idle_low: assert property (cmd_host_oe_n [*3] |-> !sclk) else $error("clock runs idle");
  a_card_stays_off: assert property (1'b1 |-> cmd_card_oe_n) else $error("card drove line");
endmodule // ccfet_properties

/* testbench/card_command_frame_and_erase_tagging_tb_top.sv */
// Bench: host end drives a card end; a second card faces a faulty driver.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module card_command_frame_and_erase_tagging_tb_top;
  typedef struct {logic [5:0] i; logic [31:0] a; logic t; logic e; logic [1:0] w; logic s;} ccfet_row_t;
  localparam logic [63:0] SUP = 64'h0000_047f_7f17_be9f;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        req = 1'b0;
  logic [5:0]  req_index = 6'h00;
  logic [31:0] req_arg = 32'h0;
  logic        busy, cmd_valid, erase_pulse, selected, cv2;
  logic [5:0]  cmd_index, li;
  logic [31:0] cmd_arg, la;
  logic [15:0] sec_tag;
  logic [3:0]  grp_tag;
  logic [1:0]  wp_bits;
  logic [11:0] card_command_class;
  int          err_count = 0, tests_run = 0, nv, ne, nv2, cyc = 0;
  ccfet_row_t  rows [10] = '{'{6'h07, 32'h10000, 0, 0, 2'h0, 1}, '{6'h1c, 32'h4000, 0, 0, 2'h2, 1},
    '{6'h20, 32'h600, 1, 0, 2'h2, 1}, '{6'h21, 32'ha00, 1, 0, 2'h2, 1}, '{6'h26, 32'h0, 0, 1, 2'h2, 1},
    '{6'h23, 32'h2000, 1, 0, 2'h2, 1}, '{6'h0d, 32'h10000, 0, 0, 2'h2, 1}, '{6'h26, 32'h0, 0, 0, 2'h2, 1},
    '{6'h1d, 32'h4000, 0, 0, 2'h0, 1}, '{6'h07, 32'h0, 0, 0, 2'h0, 0}};
  logic [47:0] bad [5] = '{48'h0, 48'h4000_0000_0000, 48'h2, 48'h1, 48'h0};
  ccfet_if bus ();
  ccfet_if bus2 ();
  // Open-drain line with pull-up
  assign bus.cmd_in = (bus.cmd_host_oe_n | bus.cmd_host_o) & (bus.cmd_card_oe_n | bus.cmd_card_o);
  assign bus2.cmd_in = (bus2.cmd_host_oe_n | bus2.cmd_host_o) & (bus2.cmd_card_oe_n | bus2.cmd_card_o);
  ccfet_host u_ccfet_host (.mclk(mclk), .rst(rst), .bus(bus.host), .req(req), .req_index(req_index),
    .req_arg(req_arg), .busy(busy));
  ccfet_card u_ccfet_card (.mclk(mclk), .rst(rst), .bus(bus.card), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
    .cmd_arg(cmd_arg), .erase_pulse(erase_pulse), .sec_tag(sec_tag), .grp_tag(grp_tag), .wp_bits(wp_bits),
    .selected(selected), .card_command_class(card_command_class));
  ccfet_card u_ccfet_card_fault (.mclk(mclk), .rst(rst), .bus(bus2.card), .cmd_valid(cv2), .cmd_index(),
    .cmd_arg(), .erase_pulse(), .sec_tag(), .grp_tag(), .wp_bits(), .selected(), .card_command_class());
  ccfet_properties u_ccfet_properties (.mclk(mclk), .rst(rst), .sclk(bus.sclk), .cmd_host_o(bus.cmd_host_o),
    .cmd_host_oe_n(bus.cmd_host_oe_n), .cmd_card_o(bus.cmd_card_o), .cmd_card_oe_n(bus.cmd_card_oe_n),
    .cmd_in(bus.cmd_in));
  // Clock
  always #25 mclk = ~mclk;
  // Pulse counters and hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cmd_valid === 1'b1) begin
      nv++;
      li = cmd_index;
      la = cmd_arg;
    end
    if (erase_pulse === 1'b1) ne++;
    if (cv2 === 1'b1) nv2++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // Frame with check bits computed here
  function automatic logic [47:0] frame(input logic [5:0] i, input logic [31:0] a);
    logic [39:0] m;
    logic [6:0]  c;
    m = {2'b01, i, a};
    c = 7'h00;
    for (int k = 39; k >= 0; k--) c = {c[5:0], 1'b0} ^ ((c[6] ^ m[k]) ? 7'h09 : 7'h00);
    return {m, c, 1'b1};
  endfunction
  // One host request, then wait for the card
  task automatic send(input logic [5:0] i, input logic [31:0] a);
    @(posedge mclk);
    #2;
    nv = 0;
    ne = 0;
    req = 1'b1;
    req_index = i;
    req_arg = a;
    @(posedge mclk);
    #2 req = 1'b0;
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge mclk);
    repeat (8) @(posedge mclk);
  endtask
  // Faulty driver: 64 ns serial clock only within the frame
  task automatic raw(input logic [47:0] f);
    #2;
    nv2 = 0;
    bus2.cmd_host_oe_n = 1'b0;
    for (int k = 47; k >= 0; k--) begin
      bus2.cmd_host_o = f[k];
      #32 bus2.sclk = 1'b1;
      #32 bus2.sclk = 1'b0;
    end
    bus2.cmd_host_oe_n = 1'b1;
    repeat (10) @(posedge mclk);
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    bus2.sclk = 1'b0;
    bus2.cmd_host_o = 1'b1;
    bus2.cmd_host_oe_n = 1'b1;
    repeat (20) @(posedge mclk);
    #2 rst = 1'b0;
    `CHK({busy, selected, wp_bits}, 4'h0)
    foreach (rows[r]) begin
      send(rows[r].i, rows[r].a);
      `CHK(nv, 1)
      `CHK({li, la}, {rows[r].i, rows[r].a})
      `CHK({|{sec_tag, grp_tag}, wp_bits, selected}, {rows[r].t, rows[r].w, rows[r].s})
      `CHK(ne, int'(rows[r].e))
    end
    `CHK(card_command_class, 12'h0ff)
    for (int n = 0; n < 64; n++) begin
      send(6'(n), 32'h0);
      `CHK(nv, int'(SUP[n]))
    end
    foreach (bad[r]) begin
      raw(frame(6'h0d, 32'h10000) ^ bad[r]);
      `CHK(nv2, int'(bad[r] == 48'h0))
    end
    tally_and_finish();
  end
endmodule // card_command_frame_and_erase_tagging_tb_top
